// ### inc/bosdb_pkg.sv
// Constants shared by the object store descriptor builder and its helpers
package bosdb_pkg;

  // Descriptor image size and byte positions, in the order sent on the wire
  localparam int DESC_BYTES = 12;
  localparam int BYTE_HDR_LEN = 0;
  localparam int BYTE_HDR_TYPE = 1;
  localparam int BYTE_TOTLEN = 2;
  localparam int BYTE_NUMCAPS = 4;
  localparam int BYTE_EXT_LEN = 5;
  localparam int BYTE_EXT_TYPE = 6;
  localparam int BYTE_EXT_CAP = 7;
  localparam int BYTE_ATTR = 8;

  // Fixed and default field values
  localparam logic [7:0] HDR_LEN = 8'h05;
  localparam logic [7:0] HDR_TYPE = 8'h0F;
  localparam logic [15:0] TOTLEN_DEF = 16'h0016;
  localparam logic [7:0] NUMCAPS_DEF = 8'h02;
  localparam logic [7:0] EXT_LEN = 8'h07;
  localparam logic [7:0] EXT_TYPE = 8'h10;
  localparam logic [7:0] EXT_CAP = 8'h02;
  localparam logic [31:0] ATTR_DEF = 32'h0000_0006;

  // Image reset contents, byte 0 in the low bits
  localparam logic [95:0] IMAGE_DEF = {ATTR_DEF, EXT_CAP, EXT_TYPE, EXT_LEN, NUMCAPS_DEF,
                                       TOTLEN_DEF, HDR_TYPE, HDR_LEN};

  // Attribute bit positions
  localparam int ATTR_LPM_BIT = 1;
  localparam int ATTR_BESL_BIT = 2;
  localparam int ATTR_BASE_VALID_BIT = 3;
  localparam int ATTR_DEEP_VALID_BIT = 4;
  localparam int ATTR_BASE_LO = 8;
  localparam int ATTR_DEEP_LO = 12;
  localparam logic [31:0] ATTR_KEEP_MASK = 32'h0000_FF1E;

  // Register byte offsets on the control bus
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_TOTLEN = 8'h08;
  localparam logic [7:0] REG_NUMCAPS = 8'h0C;
  localparam logic [7:0] REG_ATTR = 8'h10;
  localparam logic [7:0] REG_ATTR_EFF = 8'h14;
  localparam logic [7:0] REG_REQCNT = 8'h18;

  // Control and status fields
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_DEFAULTS_BIT = 1;
  localparam logic CTRL_ENABLE_RST = 1'b1;
  localparam int STAT_MISMATCH_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_LOADED_BIT = 2;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Descriptor streamer states
  typedef enum logic [1:0] {
    BOSDB_ST_IDLE = 2'b01,
    BOSDB_ST_SEND = 2'b10
  } bosdb_state_t;

endpackage

// ### design/bosdb_image.sv
// Byte-wide storage of the descriptor configuration image
`timescale 1ns/1ps
module bosdb_image #(
  parameter int NBYTES = bosdb_pkg::DESC_BYTES
) (
  input wire logic clk,                          // Core clock
  input wire logic reset,                        // Asynchronous reset, active high
  input wire logic restore,                      // Reload every byte with its default
  input wire logic [NBYTES-1:0] wr_en,           // Per-byte write enable
  input wire logic [NBYTES*8-1:0] wr_data,       // Per-byte write data
  output logic [NBYTES*8-1:0] image              // Stored image, byte 0 low
);

  logic [NBYTES*8-1:0] image_r;
  logic [NBYTES*8-1:0] image_nxt;

  // One entry per byte; a restore beats a same-cycle write
  genvar g;
  generate
    for (g = 0; g < NBYTES; g++) begin : g_byte
      always_comb begin
        image_nxt[g*8 +: 8] = image_r[g*8 +: 8];
        if (restore) begin
          image_nxt[g*8 +: 8] = bosdb_pkg::IMAGE_DEF[g*8 +: 8];
        end else if (wr_en[g]) begin
          image_nxt[g*8 +: 8] = wr_data[g*8 +: 8];
        end
      end
    end
  endgenerate

  // Register the image
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      image_r <= bosdb_pkg::IMAGE_DEF;
    end else begin
      image_r <= image_nxt;
    end
  end

  assign image = image_r;

endmodule // bosdb_image

// ### design/bosdb_assemble.sv
// Builds the sent descriptor bytes from the stored image
`timescale 1ns/1ps
module bosdb_assemble (
  input wire logic [95:0] image,                 // Stored image
  output logic [95:0] desc,                      // Descriptor as sent, byte 0 low
  output logic [31:0] attr_eff                   // Effective attribute map
);

  logic [31:0] attr_raw;

  // Attribute cleanup: reserved bits forced low, power bit forced high
  always_comb begin
    attr_raw = image[bosdb_pkg::BYTE_ATTR*8 +: 32];
    attr_eff = attr_raw & bosdb_pkg::ATTR_KEEP_MASK;
    // Latency codes and their valid flags pass as stored
    attr_eff[bosdb_pkg::ATTR_DEEP_LO +: 4] = attr_raw[bosdb_pkg::ATTR_DEEP_LO +: 4];
    attr_eff[bosdb_pkg::ATTR_BASE_LO +: 4] = attr_raw[bosdb_pkg::ATTR_BASE_LO +: 4];
    // Bit 2 needs bit 1, and bit 1 is always set on this device anyway
    attr_eff[bosdb_pkg::ATTR_LPM_BIT] = 1'b1;
  end

  // Fixed header and extension bytes override whatever the image holds
  always_comb begin
    desc = image;
    desc[bosdb_pkg::BYTE_HDR_LEN*8 +: 8] = bosdb_pkg::HDR_LEN;
    desc[bosdb_pkg::BYTE_HDR_TYPE*8 +: 8] = bosdb_pkg::HDR_TYPE;
    desc[bosdb_pkg::BYTE_EXT_LEN*8 +: 8] = bosdb_pkg::EXT_LEN;
    desc[bosdb_pkg::BYTE_EXT_TYPE*8 +: 8] = bosdb_pkg::EXT_TYPE;
    desc[bosdb_pkg::BYTE_EXT_CAP*8 +: 8] = bosdb_pkg::EXT_CAP;
    desc[bosdb_pkg::BYTE_ATTR*8 +: 32] = attr_eff;
  end

endmodule // bosdb_assemble

// ### design/bosdb_top.sv
// Object store descriptor builder with control bus and byte streamer
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module bosdb_top (
  input wire logic clk,                          // Core clock, 40 MHz
  input wire logic reset,                        // Asynchronous reset, active high
  // Control bus
  input wire logic s_axi_awvalid,                // Write address valid
  output logic s_axi_awready,                    // Write address ready
  input wire logic [7:0] s_axi_awaddr,           // Write byte address
  input wire logic s_axi_wvalid,                 // Write data valid
  output logic s_axi_wready,                     // Write data ready
  input wire logic [31:0] s_axi_wdata,           // Write data
  input wire logic [3:0] s_axi_wstrb,            // Write byte strobes
  output logic s_axi_bvalid,                     // Write response valid
  input wire logic s_axi_bready,                 // Write response ready
  output logic [1:0] s_axi_bresp,                // Write response
  input wire logic s_axi_arvalid,                // Read address valid
  output logic s_axi_arready,                    // Read address ready
  input wire logic [7:0] s_axi_araddr,           // Read byte address
  output logic s_axi_rvalid,                     // Read data valid
  input wire logic s_axi_rready,                 // Read data ready
  output logic [31:0] s_axi_rdata,               // Read data
  output logic [1:0] s_axi_rresp,                // Read response
  // Configuration loader
  input wire logic cfg_ld_valid,                 // Image byte write strobe
  input wire logic [3:0] cfg_ld_idx,             // Image byte index
  input wire logic [7:0] cfg_ld_data,            // Image byte value
  input wire logic cfg_ld_done,                  // Loader finished, one-cycle pulse
  input wire logic cfg_link_power_capable_flag,  // Power-capable flag from the image
  // Descriptor request path
  input wire logic req_valid,                    // Descriptor read request, pulse
  input wire logic [15:0] req_len,               // Bytes the host asked for
  output logic tx_valid,                         // Descriptor byte valid
  input wire logic tx_ready,                     // Descriptor byte taken
  output logic [7:0] tx_data,                    // Descriptor byte
  output logic tx_last,                          // Last byte of this block's part
  output logic busy                              // Streaming in progress
);

  localparam int NB = bosdb_pkg::DESC_BYTES;
  localparam logic [3:0] LAST_IDX = 4'(NB - 1);

  // Image storage and assembled descriptor
  logic restore;
  logic [NB-1:0] img_wr_en;
  logic [NB*8-1:0] img_wr_data;
  logic [NB*8-1:0] image;
  logic [NB*8-1:0] desc;
  logic [31:0] attr_eff;

  // Bus slave state
  logic awhold_r, awhold_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic whold_r, whold_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic do_write;
  logic do_read;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] rd_word;
  logic awready_r, awready_nxt;
  logic wready_r, wready_nxt;
  logic arready_r, arready_nxt;

  // Control and status state
  logic enable_r, enable_nxt;
  logic loaded_r, loaded_nxt;
  logic [31:0] reqcnt_r, reqcnt_nxt;

  // Streamer state
  bosdb_pkg::bosdb_state_t state_r, state_nxt;
  logic [3:0] idx_r, idx_nxt;
  logic [3:0] limit_r, limit_nxt;
  logic [NB*8-1:0] snap_r, snap_nxt;
  logic tx_valid_r, tx_valid_nxt;
  logic [7:0] tx_data_r, tx_data_nxt;
  logic tx_last_r, tx_last_nxt;
  logic [3:0] start_limit;

  bosdb_image #(
    .NBYTES(NB)
  ) u_image (
    .clk(clk),
    .reset(reset),
    .restore(restore),
    .wr_en(img_wr_en),
    .wr_data(img_wr_data),
    .image(image)
  );

  bosdb_assemble u_assemble (
    .image(image),
    .desc(desc),
    .attr_eff(attr_eff)
  );

  // Bus handshakes: address and data are taken in either order
  assign do_write = awhold_r && whold_r && !bvalid_r;
  assign do_read = s_axi_arvalid && !rvalid_r;

  always_comb begin
    awhold_nxt = awhold_r;
    awaddr_nxt = awaddr_r;
    whold_nxt = whold_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    if (s_axi_awvalid && !awhold_r) begin
      awhold_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !whold_r) begin
      whold_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (do_write) begin
      awhold_nxt = 1'b0;
      whold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_hit ? bosdb_pkg::RESP_OKAY : bosdb_pkg::RESP_SLVERR;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  // Write decode; status, effective map and counter are read only
  always_comb begin
    case (awaddr_r)
      bosdb_pkg::REG_CTRL, bosdb_pkg::REG_TOTLEN, bosdb_pkg::REG_NUMCAPS,
      bosdb_pkg::REG_ATTR: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Image byte writes; the loader wins a same-byte collision with the bus
  always_comb begin
    img_wr_en = '0;
    img_wr_data = '0;
    if (do_write) begin
      case (awaddr_r)
        bosdb_pkg::REG_TOTLEN: begin
          img_wr_en[bosdb_pkg::BYTE_TOTLEN +: 2] = wstrb_r[1:0];
          img_wr_data[bosdb_pkg::BYTE_TOTLEN*8 +: 16] = wdata_r[15:0];
        end
        bosdb_pkg::REG_NUMCAPS: begin
          img_wr_en[bosdb_pkg::BYTE_NUMCAPS] = wstrb_r[0];
          img_wr_data[bosdb_pkg::BYTE_NUMCAPS*8 +: 8] = wdata_r[7:0];
        end
        bosdb_pkg::REG_ATTR: begin
          img_wr_en[bosdb_pkg::BYTE_ATTR +: 4] = wstrb_r;
          img_wr_data[bosdb_pkg::BYTE_ATTR*8 +: 32] = wdata_r;
        end
        default: begin
          img_wr_en = '0;
        end
      endcase
    end
    // Loader may write any byte, fixed ones included; those never reach the wire
    if (cfg_ld_valid && (cfg_ld_idx <= LAST_IDX)) begin
      img_wr_en[cfg_ld_idx] = 1'b1;
      img_wr_data[cfg_ld_idx*8 +: 8] = cfg_ld_data;
    end
  end

  // Defaults restore is a self-clearing control write
  assign restore = do_write && (awaddr_r == bosdb_pkg::REG_CTRL) && wstrb_r[0] &&
                   wdata_r[bosdb_pkg::CTRL_DEFAULTS_BIT];

  // Control enable and loader-done flag
  always_comb begin
    enable_nxt = enable_r;
    loaded_nxt = loaded_r;
    if (do_write && (awaddr_r == bosdb_pkg::REG_CTRL) && wstrb_r[0]) begin
      enable_nxt = wdata_r[bosdb_pkg::CTRL_ENABLE_BIT];
    end
    if (restore) begin
      loaded_nxt = 1'b0;
    end
    // A done pulse in the restore cycle still counts
    if (cfg_ld_done) begin
      loaded_nxt = 1'b1;
    end
  end

  // Read mux; the status mismatch shows a badly programmed image
  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      bosdb_pkg::REG_CTRL: begin
        rd_word[bosdb_pkg::CTRL_ENABLE_BIT] = enable_r;
      end
      bosdb_pkg::REG_STATUS: begin
        rd_word[bosdb_pkg::STAT_MISMATCH_BIT] = cfg_link_power_capable_flag !=
          image[bosdb_pkg::BYTE_ATTR*8 + bosdb_pkg::ATTR_LPM_BIT];
        rd_word[bosdb_pkg::STAT_BUSY_BIT] = state_r == bosdb_pkg::BOSDB_ST_SEND;
        rd_word[bosdb_pkg::STAT_LOADED_BIT] = loaded_r;
      end
      bosdb_pkg::REG_TOTLEN: begin
        rd_word[15:0] = image[bosdb_pkg::BYTE_TOTLEN*8 +: 16];
      end
      bosdb_pkg::REG_NUMCAPS: begin
        rd_word[7:0] = image[bosdb_pkg::BYTE_NUMCAPS*8 +: 8];
      end
      bosdb_pkg::REG_ATTR: begin
        rd_word = image[bosdb_pkg::BYTE_ATTR*8 +: 32];
      end
      bosdb_pkg::REG_ATTR_EFF: begin
        rd_word = attr_eff;
      end
      bosdb_pkg::REG_REQCNT: begin
        rd_word = reqcnt_r;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read channel: one read under way, answer one cycle after the address
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (do_read) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = rd_word;
      rresp_nxt = rd_hit ? bosdb_pkg::RESP_OKAY : bosdb_pkg::RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  // Bytes sent for a request: the host's count capped at this block's part
  assign start_limit = (req_len >= 16'(NB)) ? 4'(NB) : req_len[3:0];

  // Streamer: snapshot at start so a loader write mid-stream cannot tear fields
  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    limit_nxt = limit_r;
    snap_nxt = snap_r;
    tx_valid_nxt = tx_valid_r;
    tx_data_nxt = tx_data_r;
    tx_last_nxt = tx_last_r;
    reqcnt_nxt = reqcnt_r;
    case (state_r)
      bosdb_pkg::BOSDB_ST_IDLE: begin
        if (req_valid && enable_r && (req_len != 16'h0000)) begin
          state_nxt = bosdb_pkg::BOSDB_ST_SEND;
          snap_nxt = desc;
          limit_nxt = start_limit;
          idx_nxt = 4'h0;
          tx_valid_nxt = 1'b1;
          tx_data_nxt = desc[7:0];
          tx_last_nxt = start_limit == 4'h1;
        end
      end
      bosdb_pkg::BOSDB_ST_SEND: begin
        if (tx_ready) begin
          if (tx_last_r) begin
            state_nxt = bosdb_pkg::BOSDB_ST_IDLE;
            tx_valid_nxt = 1'b0;
            tx_last_nxt = 1'b0;
            reqcnt_nxt = reqcnt_r + 32'h0000_0001;
          end else begin
            // Next byte in wire order, low byte of each field first
            idx_nxt = idx_r + 4'h1;
            tx_data_nxt = snap_r[(idx_r + 4'h1)*8 +: 8];
            tx_last_nxt = (idx_r + 4'h2) == limit_r;
          end
        end
      end
      default: begin
        state_nxt = bosdb_pkg::BOSDB_ST_IDLE;
        tx_valid_nxt = 1'b0;
        tx_last_nxt = 1'b0;
      end
    endcase
  end

  // Ready kept in its own flops so every bus output leaves a register, not an inverter
  assign awready_nxt = !awhold_nxt;
  assign wready_nxt = !whold_nxt;
  assign arready_nxt = !rvalid_nxt;

  // Register all state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      awhold_r <= 1'b0;
      awaddr_r <= 8'h00;
      whold_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= bosdb_pkg::RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= bosdb_pkg::RESP_OKAY;
      enable_r <= bosdb_pkg::CTRL_ENABLE_RST;
      loaded_r <= 1'b0;
      reqcnt_r <= 32'h0000_0000;
      state_r <= bosdb_pkg::BOSDB_ST_IDLE;
      idx_r <= 4'h0;
      limit_r <= 4'h0;
      snap_r <= bosdb_pkg::IMAGE_DEF;
      tx_valid_r <= 1'b0;
      tx_data_r <= 8'h00;
      tx_last_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      arready_r <= 1'b1;
    end else begin
      awhold_r <= awhold_nxt;
      awaddr_r <= awaddr_nxt;
      whold_r <= whold_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      enable_r <= enable_nxt;
      loaded_r <= loaded_nxt;
      reqcnt_r <= reqcnt_nxt;
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      limit_r <= limit_nxt;
      snap_r <= snap_nxt;
      tx_valid_r <= tx_valid_nxt;
      tx_data_r <= tx_data_nxt;
      tx_last_r <= tx_last_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      arready_r <= arready_nxt;
    end
  end

  // All outputs straight from flops
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign tx_valid = tx_valid_r;
  assign tx_data = tx_data_r;
  assign tx_last = tx_last_r;
  assign busy = tx_valid_r;

endmodule // bosdb_top

// ### testbench/bosdb_top_checker.sv
// Concurrent checks on the descriptor byte stream of the builder top
`timescale 1ns/1ps
module bosdb_top_checker (
  input wire logic clk, // Core clock
  input wire logic reset, // Asynchronous reset, active high
  input wire logic tx_valid, // Descriptor byte valid
  input wire logic tx_ready, // Descriptor byte taken
  input wire logic [7:0] tx_data, // Descriptor byte
  input wire logic tx_last, // Last byte of the block's part
  input wire logic busy // Streaming in progress
);
  logic [3:0] idx_r;
  logic [3:0] idx_nxt;

  // Byte position in the stream; cleared while idle so each send starts at zero
  always_comb begin
    idx_nxt = idx_r;
    if (tx_valid && tx_ready) begin
      idx_nxt = idx_r + 4'h1;
    end else if (!tx_valid) begin
      idx_nxt = 4'h0;
    end
  end

  // Position register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      idx_r <= 4'h0;
    end else begin
      idx_r <= idx_nxt;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_at(int n);
    tx_valid && idx_r == n;
  endsequence
  sequence s_stall;
    tx_valid && !tx_ready;
  endsequence
  sequence s_last_taken;
    tx_valid && tx_ready && idx_r == 4'hB;
  endsequence

  property p_hdr_len;
    s_at(0) |-> tx_data == 8'h05;
  endproperty
  property p_hdr_type;
    s_at(1) |-> tx_data == 8'h0F;
  endproperty
  property p_ext_fixed;
    tx_valid && idx_r >= 4'h5 && idx_r <= 4'h7 |->
      tx_data == ((idx_r == 4'h5) ? 8'h07 : (idx_r == 4'h6) ? 8'h10 : 8'h02);
  endproperty
  property p_attr_low;
    s_at(8) |-> tx_data[1] && !tx_data[0];
  endproperty
  property p_attr_b2;
    s_at(8) ##0 tx_data[2] |-> tx_data[1];
  endproperty
  property p_attr_hi;
    tx_valid && idx_r >= 4'hA && idx_r <= 4'hB |-> tx_data == 8'h00;
  endproperty
  property p_hold;
    s_stall |=> tx_valid && $stable(tx_data) && $stable(tx_last);
  endproperty
  property p_last_pos;
    s_at(11) |-> tx_last;
  endproperty
  property p_last_end;
    s_last_taken |=> !tx_valid;
  endproperty
  property p_busy;
    busy == tx_valid;
  endproperty

  a_hdr_len: assert property (p_hdr_len) else $error("header length byte wrong");
  a_hdr_type: assert property (p_hdr_type) else $error("header type byte wrong");
  a_ext_fixed: assert property (p_ext_fixed) else $error("extension fixed byte wrong");
  a_attr_low: assert property (p_attr_low) else $error("attribute bit 1 or 0 wrong");
  a_attr_b2: assert property (p_attr_b2) else $error("bit 2 set without bit 1");
  a_attr_hi: assert property (p_attr_hi) else $error("attribute upper half not zero");
  a_hold: assert property (p_hold) else $error("byte changed while stalled");
  a_last_pos: assert property (p_last_pos) else $error("twelfth byte not marked last");
  a_last_end: assert property (p_last_end) else $error("stream ran past last byte");
  a_busy: assert property (p_busy) else $error("busy disagrees with byte valid");
endmodule // bosdb_top_checker

bind bosdb_top bosdb_top_checker i_chk (
  .clk(clk),
  .reset(reset),
  .tx_valid(tx_valid),
  .tx_ready(tx_ready),
  .tx_data(tx_data),
  .tx_last(tx_last),
  .busy(busy)
);

// ### testbench/bosdb_host_model.sv
// Host-side reader model that requests and consumes descriptor bytes
`timescale 1ns/1ps
module bosdb_host_model (
  input wire logic clk, // Core clock
  input wire logic tx_valid, // Byte valid
  input wire logic [7:0] tx_data, // Byte value
  input wire logic tx_last, // Last byte flag
  output logic tx_ready, // Byte accept
  output logic req_valid, // Request pulse
  output logic [15:0] req_len // Requested length
);
  logic [7:0] got[$];
  int last_at;

  initial begin
    tx_ready = 1'b0;
    req_valid = 1'b0;
    req_len = 16'h0000;
  end

  // Request, then take bytes; a slow host accepts only every other cycle
  task automatic fetch(input logic [15:0] len, input bit slow);
    int k;
    int n;
    n = (len < 16'h000C) ? int'(len) : 12;
    got.delete();
    last_at = -1;
    @(posedge clk);
    req_valid <= 1'b1;
    req_len <= len;
    @(posedge clk);
    req_valid <= 1'b0;
    req_len <= ~len; // Length is not held past the pulse
    for (k = 0; k < 400 && got.size() < n; k++) begin
      tx_ready <= !slow || k[0];
      @(posedge clk);
      if (tx_valid && tx_ready) begin
        got.push_back(tx_data);
        if (tx_last) last_at = got.size() - 1;
      end
    end
    tx_ready <= 1'b0;
  endtask
endmodule // bosdb_host_model

// ### testbench/bos_descriptor_builder_tb.sv
// Self-checking bench for the object store descriptor builder
`timescale 1ns/1ps
module bos_descriptor_builder_tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic cfg_ld_valid = 1'b0, cfg_ld_done = 1'b0;
  logic [3:0] cfg_ld_idx = 4'h0;
  logic [7:0] cfg_ld_data = 8'h00;
  logic cfg_link_power_capable_flag = 1'b1;
  logic req_valid, tx_valid, tx_ready, tx_last, busy;
  logic [15:0] req_len;
  logic [7:0] tx_data;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;

  bosdb_top i_dut (.clk(clk), .reset(reset), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .cfg_ld_valid(cfg_ld_valid), .cfg_ld_idx(cfg_ld_idx),
    .cfg_ld_data(cfg_ld_data), .cfg_ld_done(cfg_ld_done),
    .cfg_link_power_capable_flag(cfg_link_power_capable_flag), .req_valid(req_valid),
    .req_len(req_len), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .tx_last(tx_last), .busy(busy));

  bosdb_host_model i_host (.clk(clk), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready), .req_valid(req_valid), .req_len(req_len));

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end

  task automatic results();
    if (err_total == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Bus write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic ld(input logic [3:0] i, input logic [7:0] v);
    @(posedge clk);
    cfg_ld_valid <= 1'b1;
    cfg_ld_idx <= i;
    cfg_ld_data <= v;
    @(posedge clk);
    cfg_ld_valid <= 1'b0;
  endtask

  // Expected descriptor, byte 0 low, multi-byte fields low byte first
  function automatic logic [95:0] mk(logic [15:0] tl, logic [7:0] nc, logic [31:0] at);
    return {at, 8'h02, 8'h10, 8'h07, nc, tl, 8'h0F, 8'h05};
  endfunction

  // One host read of the descriptor and a byte-by-byte comparison
  task automatic see(input logic [15:0] len, input bit slow, input logic [95:0] e);
    int n;
    n = (len < 16'h000C) ? int'(len) : 12;
    i_host.fetch(len, slow);
    chk(32'(i_host.got.size()), 32'(n));
    for (int i = 0; i < n; i++) chk({24'h0, i_host.got[i]}, {24'h0, e[i*8+:8]});
    if (n == 12) chk(32'(i_host.last_at), 32'h0000_000B);
  endtask

  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    rd(bosdb_pkg::REG_TOTLEN, d, r);
    chk(d, 32'h0000_0016);
    rd(bosdb_pkg::REG_NUMCAPS, d, r);
    chk(d, 32'h0000_0002);
    rd(bosdb_pkg::REG_ATTR, d, r);
    chk(d, 32'h0000_0006);
    rd(8'h40, d, r);
    chk({30'h0, r}, 32'h0000_0002);
  endtask

  task automatic t_loader();
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 13; i++) ld(4'(i), 8'hFF);
    @(posedge clk);
    cfg_ld_done <= 1'b1;
    @(posedge clk);
    cfg_ld_done <= 1'b0;
    rd(bosdb_pkg::REG_STATUS, d, r);
    chk(d & 32'h0000_0005, 32'h0000_0004);
    see(16'h0100, 1'b0, mk(16'hFFFF, 8'hFF, 32'h0000_FF1E));
  endtask

  task automatic t_bus();
    logic [31:0] d;
    logic [1:0] r;
    wr(bosdb_pkg::REG_CTRL, 32'h0000_0003, r);
    chk({30'h0, r}, 32'h0000_0000);
    @(posedge clk);
    cfg_link_power_capable_flag <= 1'b0;
    wr(bosdb_pkg::REG_ATTR, 32'h0001_A705, r);
    rd(bosdb_pkg::REG_ATTR_EFF, d, r);
    chk(d, 32'h0000_A706);
    rd(bosdb_pkg::REG_STATUS, d, r);
    chk(d & 32'h0000_0001, 32'h0000_0000);
    wr(bosdb_pkg::REG_TOTLEN, 32'h0000_1234, r);
    wr(bosdb_pkg::REG_NUMCAPS, 32'h0000_0003, r);
    wr(bosdb_pkg::REG_STATUS, 32'h0000_0000, r);
    chk({30'h0, r}, 32'h0000_0002);
    see(16'h0005, 1'b1, mk(16'h1234, 8'h03, 32'h0));
    see(16'h000C, 1'b1, mk(16'h1234, 8'h03, 32'h0000_A706));
  endtask

  // Finished-send counter, then a disabled block must ignore a request
  task automatic t_ctrl();
    logic [31:0] d;
    logic [1:0] r;
    rd(bosdb_pkg::REG_REQCNT, d, r);
    chk(d, 32'h0000_0004);
    wr(bosdb_pkg::REG_CTRL, 32'h0000_0000, r);
    rd(bosdb_pkg::REG_CTRL, d, r);
    chk(d, 32'h0000_0000);
    i_host.fetch(16'h000C, 1'b0);
    chk(32'(i_host.got.size()), 32'h0000_0000);
    chk({31'h0, busy}, 32'h0000_0000);
    rd(bosdb_pkg::REG_REQCNT, d, r);
    chk(d, 32'h0000_0004);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    see(16'h000C, 1'b1, mk(16'h0016, 8'h02, 32'h0000_0006));
    t_loader();
    t_bus();
    t_ctrl();
    results();
  end
endmodule // bos_descriptor_builder_tb
